// file: hdl/tphp_top.sv
// Byte-wide token-passing host port, transceiver side
//
// Function
// R1: Host keeps chip select low for each whole byte operation.
// R2: Host drives read/write low for write, high for read.
// R3: Select low gives eight data bits; select high puts handshake on line 0.
// R4: Status read shows handshake low when ready, high when busy.
// R5: Right after a host write the handshake reads busy until next byte is possible.
// R6: Host passes token with zero length then zero token, polling between.
// R7: Holding token with nothing to send, stay busy until a byte is available.
// R8: First byte sent is length; zero length hands token back to host.
// R9: After reset host polls handshake until reset processing is done.
// R10: Reset line only asserted by the device on a genuine self-reset.
// R11: Host packet is nonzero length, data bytes, then zero token byte.
// R12: Host resets by driving reset line, then releasing it to input.
// R13: Inside a frame, a missed byte before timeout makes the device reset itself; the code runs no timeout in ST_HOST_FIRST.
// R14: Host floats its data drivers during every read.
`timescale 1ns/10ps
module tphp_top
    import tphp_pkg::*;
#(
    parameter logic [TMO_W-1:0] TMO_CYC_P = TMO_W'(TMO_CYC)
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic              cs_n_in,
    input  wire logic              rw_in,
    input  wire logic              register_select_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_n_out,
    input  wire logic              reset_line_in,
    output logic                   reset_line_out,
    output logic                   reset_line_oe_n_out,
    input  wire logic              up_valid_in,
    input  wire logic [DATA_W-1:0] up_data_in,
    output logic                   up_ready_out,
    output logic                   dn_valid_out,
    output logic      [DATA_W-1:0] dn_data_out,
    input  wire logic              dn_ready_in,
    output logic                   token_held_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    tphp_state_t       state_r;
    tphp_state_t       state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [7:0]        proc_r;
    logic [7:0]        proc_nxt;
    logic [3:0]        pulse_r;
    logic [3:0]        pulse_nxt;
    logic [TMO_W-1:0]  tmo_r;
    logic [TMO_W-1:0]  tmo_nxt;
    logic              cs_d_r;
    logic              op_rw_r;
    logic              op_rw_nxt;
    logic              op_rs_r;
    logic              op_rs_nxt;
    logic              op_rdy_r;
    logic              op_rdy_nxt;
    logic [7:0]        wr_byte_r;
    logic [7:0]        wr_byte_nxt;
    logic              dn_valid_r;
    logic              dn_valid_nxt;
    logic [7:0]        dn_data_r;
    logic [7:0]        dn_data_nxt;
    logic [7:0]        dout_r;
    logic [7:0]        dout_nxt;
    logic              oe_n_r;
    logic              oe_n_nxt;
    logic              rl_oe_n_r;
    logic              rl_oe_n_nxt;
    logic              rl_lvl_r;
    logic              tok_r;
    logic              tok_nxt;
    logic              cs_s;
    logic              rw_s;
    logic              rs_s;
    logic [7:0]        din_s;
    logic              host_rst;
    logic              op_start;
    logic              op_end;
    logic              rd_act;
    logic              busy_w;
    logic              acc_wr;
    logic              pop_w;
    logic              byte_done;
    logic              tmo_hit;

    tphp_fifo_if #(.W(DATA_W)) fifo_bus ();

    // States in which the host holds the token
    function automatic logic is_host(input tphp_state_t s);
        return (s == ST_HOST_IDLE) || (s == ST_HOST_NULL) || (s == ST_HOST_FIRST) ||
               (s == ST_HOST_DATA) || (s == ST_HOST_TOKEN);
    endfunction

    // States inside a frame where the byte timeout runs
    function automatic logic is_fast(input tphp_state_t s);
        return (s == ST_HOST_NULL) || (s == ST_HOST_DATA) ||
               (s == ST_HOST_TOKEN) || (s == ST_DEV_DATA);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: two stages before any logic looks at a pin
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else if (ce_in) begin
            sync1_r <= {reset_line_in, cs_n_in, rw_in, register_select_in, data_in};
            sync2_r <= sync1_r;
        end
    end

    assign cs_s     = sync2_r[SY_CS_N];
    assign rw_s     = sync2_r[SY_RW];
    assign rs_s     = sync2_r[SY_RSEL];
    assign din_s    = sync2_r[DATA_W-1:0];
    assign host_rst = (sync2_r[SY_RLINE] == RLINE_ASSERT);
    assign op_start = ~cs_s & cs_d_r;
    assign op_end   = cs_s & ~cs_d_r;  // A byte operation ends as select rises
    assign rd_act   = ~cs_s & rw_s;

    ////////////////////////////////////////////////////////////////////////////
    // Handshake: busy in reset, while a written byte is pending, or with no byte
    always_comb begin
        case (state_r)
            ST_RESET:    busy_w = HS_BUSY;
            ST_DEV_WAIT: busy_w = ~fifo_bus.pop_valid | dn_valid_r;  // R5 R7
            ST_DEV_DATA: busy_w = ~fifo_bus.pop_valid;
            default:     busy_w = dn_valid_r;  // R5
        endcase
    end

    // Byte moves; only operations begun while ready are honoured
    assign acc_wr = ce_in & op_end & ~op_rw_r & ~op_rs_r & op_rdy_r &
                    is_host(state_r) & ~dn_valid_r & ~host_rst;
    assign pop_w  = ce_in & op_end & op_rw_r & ~op_rs_r & op_rdy_r &
                    ~is_host(state_r) & (state_r != ST_RESET) &
                    fifo_bus.pop_valid & ~host_rst;
    assign byte_done = acc_wr | pop_w;
    assign tmo_hit   = ce_in & is_fast(state_r) & ~byte_done & ~host_rst &
                       (tmo_r == TMO_CYC_P - 24'h000001);  // R13

    ////////////////////////////////////////////////////////////////////////////
    // Uplink FIFO between the device application and the data register
    assign fifo_bus.push_valid = up_valid_in;
    assign fifo_bus.push_data  = up_data_in;
    assign fifo_bus.pop_ready  = pop_w;
    assign fifo_bus.clr        = host_rst | tmo_hit;
    assign up_ready_out        = fifo_bus.push_ready;

    tphp_fifo #(
        .W     (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .bus      (fifo_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for token protocol, pins and timers
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        proc_nxt     = proc_r;
        pulse_nxt    = pulse_r;
        op_rw_nxt    = op_rw_r;
        op_rs_nxt    = op_rs_r;
        op_rdy_nxt   = op_rdy_r;
        wr_byte_nxt  = wr_byte_r;
        dn_valid_nxt = dn_valid_r & ~dn_ready_in;
        dn_data_nxt  = dn_data_r;
        // Timer restarts on every byte and outside frames
        tmo_nxt      = (is_fast(state_r) && !byte_done) ? tmo_r + 24'h000001 : '0;
        // Capture the operation while chip select is low
        if (op_start) begin
            op_rdy_nxt = ~busy_w;
        end
        if (!cs_s) begin
            op_rw_nxt = rw_s;
            op_rs_nxt = rs_s;
            if (!rw_s) begin
                wr_byte_nxt = din_s;
            end
        end
        // Register select picks handshake or data byte for reads
        oe_n_nxt = ~rd_act;
        dout_nxt = rs_s ? {7'h00, busy_w} : fifo_bus.pop_data;  // R3 R4
        // Accepted host bytes go out downlink
        if (acc_wr) begin
            dn_valid_nxt = 1'b1;
            dn_data_nxt  = wr_byte_r;
        end
        if (pulse_r != 4'h0) begin
            pulse_nxt = pulse_r - 4'h1;
        end
        case (state_r)
            ST_RESET: begin
                if (pulse_r == 4'h0) begin
                    proc_nxt = proc_r + 8'h01;
                    if (proc_r == PROC_LAST) begin
                        state_nxt = ST_HOST_IDLE;
                    end
                end
            end
            ST_HOST_IDLE: begin
                if (acc_wr) begin
                    cnt_nxt   = wr_byte_r;
                    state_nxt = (wr_byte_r == NULL_BYTE) ? ST_HOST_NULL : ST_HOST_FIRST;
                end
            end
            ST_HOST_FIRST, ST_HOST_DATA: begin
                if (acc_wr) begin
                    cnt_nxt   = cnt_r - 8'h01;
                    state_nxt = (cnt_r == 8'h01) ? ST_HOST_TOKEN : ST_HOST_DATA;
                end
            end
            ST_HOST_NULL, ST_HOST_TOKEN: begin
                if (acc_wr) begin
                    state_nxt = ST_DEV_WAIT;
                end
            end
            ST_DEV_WAIT: begin
                // First byte read is the length; zero returns the token
                if (pop_w) begin
                    cnt_nxt   = fifo_bus.pop_data;
                    state_nxt = (fifo_bus.pop_data == NULL_BYTE) ? ST_HOST_IDLE
                                                                 : ST_DEV_DATA;  // R8
                end
            end
            default: begin
                if (pop_w) begin
                    cnt_nxt   = cnt_r - 8'h01;
                    state_nxt = (cnt_r == 8'h01) ? ST_DEV_WAIT : ST_DEV_DATA;
                end
            end
        endcase
        // Self-reset on a lost byte drives the reset line
        if (tmo_hit) begin
            pulse_nxt = PULSE_LOAD;  // R13
        end
        if (host_rst || tmo_hit) begin
            state_nxt    = ST_RESET;
            proc_nxt     = '0;
            cnt_nxt      = '0;
            dn_valid_nxt = 1'b0;
        end
        rl_oe_n_nxt = (pulse_nxt == 4'h0);  // R10
        tok_nxt     = ~is_host(state_nxt) & (state_nxt != ST_RESET);
    end

    // State registers, frozen while the clock enable is low
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r    <= ST_RESET;
            cnt_r      <= '0;
            proc_r     <= '0;
            pulse_r    <= '0;
            tmo_r      <= '0;
            cs_d_r     <= 1'b1;
            op_rw_r    <= 1'b1;
            op_rs_r    <= 1'b1;
            op_rdy_r   <= 1'b0;
            wr_byte_r  <= '0;
            dn_valid_r <= 1'b0;
            dn_data_r  <= '0;
            dout_r     <= '0;
            oe_n_r     <= 1'b1;
            rl_oe_n_r  <= 1'b1;
            rl_lvl_r   <= RLINE_ASSERT;
            tok_r      <= 1'b0;
        end else if (ce_in) begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            proc_r     <= proc_nxt;
            pulse_r    <= pulse_nxt;
            tmo_r      <= tmo_nxt;
            cs_d_r     <= cs_s;
            op_rw_r    <= op_rw_nxt;
            op_rs_r    <= op_rs_nxt;
            op_rdy_r   <= op_rdy_nxt;
            wr_byte_r  <= wr_byte_nxt;
            dn_valid_r <= dn_valid_nxt;
            dn_data_r  <= dn_data_nxt;
            dout_r     <= dout_nxt;
            oe_n_r     <= oe_n_nxt;
            rl_oe_n_r  <= rl_oe_n_nxt;
            rl_lvl_r   <= RLINE_ASSERT;
            tok_r      <= tok_nxt;
        end
    end

    assign data_out            = dout_r;
    assign data_oe_n_out       = oe_n_r;
    assign reset_line_out      = rl_lvl_r;
    assign reset_line_oe_n_out = rl_oe_n_r;
    assign dn_valid_out        = dn_valid_r;
    assign dn_data_out         = dn_data_r;
    assign token_held_out      = tok_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the pin protocol
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Reset pulse: eight cycles driven, then released
    sequence s_rst_pulse;
        (!reset_line_oe_n_out)[*8] ##1 reset_line_oe_n_out;
    endsequence

    a_status_bit: assert property ( // R3
        (ce_in && rd_act && rs_s) |=> (!data_oe_n_out && data_out[7:1] == 7'h00 &&
                                      data_out[HS_BIT] == $past(busy_w)))
        else $error("status read does not show handshake on line zero");

    a_data_byte: assert property ( // R3
        (ce_in && rd_act && !rs_s) |=> (data_out == $past(fifo_bus.pop_data)))
        else $error("data read does not show the uplink byte");

    a_ready_state: assert property ( // R9
        (busy_w == HS_READY) |-> (state_r != ST_RESET))
        else $error("handshake ready during reset processing");

    a_busy_write: assert property ( // R5
        (ce_in && acc_wr) |=> (busy_w == HS_BUSY && dn_valid_out))
        else $error("handshake not busy right after a host write");

    a_token_hold: assert property ( // R7
        (state_r == ST_DEV_WAIT && !fifo_bus.pop_valid) |-> (busy_w == HS_BUSY))
        else $error("ready while holding token with nothing to send");

    a_null_len: assert property ( // R8
        (pop_w && state_r == ST_DEV_WAIT && fifo_bus.pop_data == NULL_BYTE && !tmo_hit)
        |=> (state_r == ST_HOST_IDLE && !token_held_out))
        else $error("zero length did not return the token");

    a_rst_cause: assert property ( // R10
        $fell(reset_line_oe_n_out) |-> $past(tmo_hit))
        else $error("reset line driven without a timeout");

    a_tmo_reset: assert property ( // R13
        tmo_hit |=> (state_r == ST_RESET) and s_rst_pulse)
        else $error("timeout did not produce a self reset");
endmodule // tphp_top

// file: shared/tphp_pkg.sv
// Constants and types shared by the token parallel host port
package tphp_pkg;
    localparam int              DATA_W        = 8;
    localparam int              FIFO_DEPTH    = 8;
    localparam int              SYNC_W        = 12;
    // Synchroniser reset: reset line high, chip select high, read, status
    localparam logic [11:0]     SYNC_RST      = 12'hf00;
    // Pin positions inside the synchronised vector
    localparam int              SY_RLINE      = 11;
    localparam int              SY_CS_N       = 10;
    localparam int              SY_RW         = 9;
    localparam int              SY_RSEL       = 8;
    // Bit of the data lines that carries the handshake flag on a status read
    localparam int              HS_BIT        = 0;
    localparam logic            HS_BUSY       = 1'b1;
    localparam logic            HS_READY      = 1'b0;
    localparam logic [7:0]      NULL_BYTE     = 8'h00;
    localparam logic            RLINE_ASSERT  = 1'b0;
    // Fast-I/O timeout: shortest printed figure at the reference clock
    localparam int              TMO_MIN_US    = 210000;
    localparam int              TMO_REF_MHZ   = 40;
    // The timeout is a fixed number of transceiver clocks at any rate
    localparam int              TMO_CYC       = TMO_MIN_US * TMO_REF_MHZ;
    localparam int              TMO_W         = 24;
    // Reset processing length and self-reset pulse on the reset line
    localparam int              RST_PROC_CYC  = 16;
    localparam logic [7:0]      PROC_LAST     = 8'(RST_PROC_CYC - 1);
    localparam int              RST_PULSE_CYC = 8;
    localparam logic [3:0]      PULSE_LOAD    = 4'(RST_PULSE_CYC);
    localparam int              CNT_W         = 8;

    // Token ownership and position inside a frame
    typedef enum logic [2:0] {
        ST_RESET,
        ST_HOST_IDLE,
        ST_HOST_NULL,
        ST_HOST_FIRST,
        ST_HOST_DATA,
        ST_HOST_TOKEN,
        ST_DEV_WAIT,
        ST_DEV_DATA
    } tphp_state_t;
endpackage

// file: shared/tphp_fifo_if.sv
// Push and pop handshake bundle between the host port and its uplink FIFO
`timescale 1ns/10ps
interface tphp_fifo_if #(parameter int W = 8);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;
    logic         clr;

    modport fifo (
        input  push_valid,
        input  push_data,
        input  pop_ready,
        input  clr,
        output push_ready,
        output pop_valid,
        output pop_data
    );
    modport user (
        output push_valid,
        output push_data,
        output pop_ready,
        output clr,
        input  push_ready,
        input  pop_valid,
        input  pop_data
    );
endinterface // tphp_fifo_if

// file: hdl/tphp_fifo.sv
// Uplink byte FIFO with registered full and empty flags
`timescale 1ns/10ps
module tphp_fifo
    import tphp_pkg::*;
#(
    parameter int W     = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  ce_in,
    tphp_fifo_if.fifo  bus
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] wp_nxt;
    logic [AW-1:0] rp_r;
    logic [AW-1:0] rp_nxt;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          nfull_r;
    logic          nfull_nxt;
    logic          nempty_r;
    logic          nempty_nxt;
    logic          push_w;
    logic          pop_w;

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes only complete while the clock enable is high
    assign push_w = ce_in & bus.push_valid & nfull_r & ~bus.clr;
    assign pop_w  = ce_in & bus.pop_ready & nempty_r & ~bus.clr;

    // Pointer and level arithmetic; clear empties the buffer
    always_comb begin
        wp_nxt  = wp_r + AW'(push_w);
        rp_nxt  = rp_r + AW'(pop_w);
        cnt_nxt = cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
        if (bus.clr) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end
        nfull_nxt  = (cnt_nxt != (AW+1)'(DEPTH));
        nempty_nxt = (cnt_nxt != '0);
    end

    // Pointer and flag registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_r     <= '0;
            rp_r     <= '0;
            cnt_r    <= '0;
            nfull_r  <= 1'b1;
            nempty_r <= 1'b0;
        end else if (ce_in) begin
            wp_r     <= wp_nxt;
            rp_r     <= rp_nxt;
            cnt_r    <= cnt_nxt;
            nfull_r  <= nfull_nxt;
            nempty_r <= nempty_nxt;
        end
    end

    // Storage array, written without reset
    always_ff @(posedge clk_in) begin
        if (push_w) begin
            mem[wp_r] <= bus.push_data;
        end
    end

    assign bus.push_ready = nfull_r;  // Flags come from flip-flops
    assign bus.pop_valid  = nempty_r;
    assign bus.pop_data   = mem[rp_r];
endmodule // tphp_fifo

// file: verif/tphp_host_model.sv
// Host processor model driving the pin-level parallel port
`timescale 1ns/10ps
module tphp_host_model
    import tphp_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [DATA_W-1:0] dev_data_in,
    input  wire logic              dev_oe_n_in,
    input  wire logic              dev_rl_in,
    input  wire logic              dev_rl_oe_n_in,
    output logic                   cs_n_out,
    output logic                   rw_out,
    output logic                   rsel_out,
    output logic      [DATA_W-1:0] data_out,
    output logic                   rline_out
);
    logic              drv     = 1'b0;
    logic              rst_drv = 1'b0;
    logic [DATA_W-1:0] hd      = 8'h00;
    logic [DATA_W-1:0] last_d  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle pin levels
    initial begin
        cs_n_out = 1'b1;
        rw_out   = 1'b1;
        rsel_out = 1'b1;
    end

    // Data wire: device, else host, else a changing float pattern
    assign data_out = !dev_oe_n_in ? dev_data_in : (drv ? hd : ~last_d);
    always @(posedge clk_in) last_d <= data_out;

    // Reset wire has a pull-up
    assign rline_out = ((!dev_rl_oe_n_in && dev_rl_in == RLINE_ASSERT) || rst_drv) ?
                       RLINE_ASSERT : ~RLINE_ASSERT;

    ////////////////////////////////////////////////////////////////////////////////
    // One byte operation with chip select held throughout
    task automatic op(input logic rd, input logic sel, input logic [7:0] wd,
                      output logic [7:0] q);
        @(posedge clk_in);
        #1;
        cs_n_out = 1'b0;
        rw_out   = rd;
        rsel_out = sel;
        hd       = wd;
        drv      = !rd;
        repeat (6) @(posedge clk_in);
        q = data_out;
        #1;
        cs_n_out = 1'b1;
        drv      = 1'b0;
        repeat (5) @(posedge clk_in);
    endtask

    // Drive the shared reset wire, then float it again
    task automatic hw_reset();
        @(posedge clk_in);
        #1;
        rst_drv = 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
        rst_drv = 1'b0;
    endtask
endmodule // tphp_host_model

// file: verif/token_parallel_host_port_test.sv
// Self-checking bench for the token parallel host port
`timescale 1ns/10ps
module token_parallel_host_port_test
    import tphp_pkg::*;
;
    localparam int TMO_SIM = 200;
    logic       clk_in = 1'b0, rst_n_in = 1'b0, up_valid_in = 1'b0, dn_ready_in = 1'b1;
    logic [7:0] up_data_in = 8'h00, q;
    logic [7:0] dnq[$];
    wire        cs_n, rw, rsel, rline, oe_n, rlo, rloe, up_ready_out, dn_valid_out, tok;
    wire  [7:0] dline, dout, dn_data_out;
    int         n_mismatch = 0, num_checks = 0, n_self = 0;

    always #50 clk_in = ~clk_in;

    tphp_top #(.TMO_CYC_P(TMO_W'(TMO_SIM))) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ce_in(1'b1), .cs_n_in(cs_n), .rw_in(rw), .register_select_in(rsel),
        .data_in(dline), .data_out(dout), .data_oe_n_out(oe_n), .reset_line_in(rline),
        .reset_line_out(rlo), .reset_line_oe_n_out(rloe), .up_valid_in(up_valid_in),
        .up_data_in(up_data_in), .up_ready_out(up_ready_out), .dn_valid_out(dn_valid_out),
        .dn_data_out(dn_data_out), .dn_ready_in(dn_ready_in), .token_held_out(tok));

    tphp_host_model u_host (.clk_in(clk_in), .dev_data_in(dout), .dev_oe_n_in(oe_n),
        .dev_rl_in(rlo), .dev_rl_oe_n_in(rloe), .cs_n_out(cs_n), .rw_out(rw),
        .rsel_out(rsel), .data_out(dline), .rline_out(rline));

    // Collect every byte accepted downlink, count self resets
    always @(posedge clk_in) if (dn_valid_out === 1'b1 && dn_ready_in) dnq.push_back(dn_data_out);
    always @(negedge rloe) n_self++;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches=%0d checks=%0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic status(input logic [7:0] exp);
        u_host.op(1'b1, 1'b1, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 40; i++) begin
            u_host.op(1'b1, 1'b1, 8'h00, q);
            if (q === 8'h00) break;
        end
        chk(q, 8'h00);
    endtask
    task automatic wr(input logic [7:0] b);
        wait_ready();
        u_host.op(1'b0, 1'b0, b, q);
    endtask
    task automatic rd(input logic [7:0] exp);
        wait_ready();
        u_host.op(1'b1, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic dn(input logic [7:0] exp);
        logic [7:0] g;
        g = (dnq.size() > 0) ? dnq.pop_front() : 8'hxx;
        chk(g, exp);
    endtask
    task automatic push(input logic [7:0] b);
        int i;
        @(posedge clk_in);
        #1;
        up_valid_in = 1'b1;
        up_data_in  = b;
        i = 0;
        @(posedge clk_in);
        while (up_ready_out !== 1'b1 && i < 20) begin
            @(posedge clk_in);
            i++;
        end
        #1;
        up_valid_in = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        status(8'h01);
        wait_ready();
        chk({7'h00, rloe}, 8'h01);
        chk({7'h00, tok}, 8'h00);
    endtask
    task automatic t_host_pkt();
        @(posedge clk_in);
        #1;
        dn_ready_in = 1'b0;
        wr(8'h02);
        status(8'h01);
        @(posedge clk_in);
        #1;
        dn_ready_in = 1'b1;
        wr(8'ha5);
        wr(8'h5a);
        wr(8'h00);
        dn(8'h02);
        dn(8'ha5);
        dn(8'h5a);
        dn(8'h00);
        chk({7'h00, tok}, 8'h01);
    endtask
    task automatic t_dev_pkt();
        logic [7:0] f[8] = '{8'h02, 8'h81, 8'h7e, 8'h00, 8'h02, 8'h3c, 8'hc3, 8'h00};
        status(8'h01);
        foreach (f[i]) push(f[i]);
        chk({7'h00, up_ready_out}, 8'h00);
        for (int i = 0; i < 4; i++) rd(f[i]);
        chk({7'h00, tok}, 8'h00);
        wr(8'h00);
        wr(8'h00);
        dn(8'h00);
        dn(8'h00);
        for (int i = 4; i < 8; i++) rd(f[i]);
        chk({7'h00, tok}, 8'h00);
        chk({7'h00, up_ready_out}, 8'h01);
    endtask
    task automatic t_timeout();
        int i;
        wr(8'h00);
        for (i = 0; i < TMO_SIM + 100; i++) begin
            @(posedge clk_in);
            if (rloe === 1'b0) break;
        end
        chk({7'h00, rloe}, 8'h00);
        wait_ready();
        chk({7'h00, tok}, 8'h00);
        dn(8'h00);
    endtask
    task automatic t_hw_reset();
        u_host.hw_reset();
        status(8'h01);
        wait_ready();
        chk(8'(n_self), 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (6) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        t_reset();
        t_host_pkt();
        t_dev_pkt();
        t_timeout();
        t_hw_reset();
        close_out();
    end
    initial begin
        #3000000;
        n_mismatch++;
        close_out();
    end
endmodule // token_parallel_host_port_test
